//--- bsc_top.sv
// Purpose: reset-time strap capture, config register decode and serial boot load
// Assumes: straps on md_pin are stable around reset release and soft reset
// Notes:   loaded bytes leave on load_wr; no buffering
// How it works
// R1 - data pin straps are sampled for three cycles after hard reset release or soft reset
// R2 - board pulls strap pins high for ones; pins default low otherwise
// R3 - strap bit 6 selects extra i/o decoding of function registers
// R4 - with i/o decode set, answer at offsets 0x40, 0x42, 0x44
// R5 - with i/o decode clear, those registers are attribute space only
// R6 - i/o decode strap ignored when parallel host enable strap is zero
// R7 - isa mode strap forces i/o decode on
// R8 - type 00: large serial device, firmware copied into sram
// R9 - type 01: small device holds only cis, then idle awaiting host
// R10 - type 1x unsupported: no load sequence runs
// R11 - serial boot clock runs at 400 kHz
// R12 - latched straps hold until the next hard or soft reset
`timescale 1ns/1ps
module bsc_top #(
    parameter int FW_LEN  = 4096,
    parameter int CIS_LEN = 256
) (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      clk_en,
    input  wire logic [15:0]               md_pin,
    input  wire logic                      parallel_host_enable,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [31:0]               reg_rdata,
    input  wire logic                      host_io_req,
    input  wire logic [7:0]                host_io_off,
    output logic                           config_option_io_sel,
    output logic                           card_status_io_sel,
    output logic                           pin_replacement_io_sel,
    output logic                           function_regs_in_io,
    output logic                           nv_sck,
    output logic                           nv_cs_n,
    output logic                           nv_sdo,
    input  wire logic                      nv_sdi,
    output bsc_pkg::bsc_load_wr_type       load_wr,
    output logic                           wait_host
);

    logic [15:0]            md_sync;
    logic                   phe_sync;
    logic                   sdi_sync;
    logic [1:0]             capture_cnt;
    logic                   capturing;
    logic                   soft_go;
    bsc_pkg::bsc_strap_type strap;
    logic                   phe_strap;
    logic                   io_en;
    bsc_pkg::bsc_state_type state;
    logic                   xfer;
    logic                   rise_tick;
    logic                   fall_tick;
    logic [31:0]            shift_out;
    logic [7:0]             shift_in;
    logic [4:0]             bit_cnt;
    logic [15:0]            byte_cnt;
    logic [15:0]            load_len;
    logic                   to_sram;

    // pins cross into the clock domain
    bsc_sync2 #(.W(18)) u_sync (
        .clk    (clk),
        .rstn   (rstn),
        .clk_en (clk_en),
        .din    ({md_pin, parallel_host_enable, nv_sdi}),
        .dout   ({md_sync, phe_sync, sdi_sync})
    );

    // soft reset request from software
    assign soft_go = reg_wr && (reg_addr == bsc_pkg::REG_CTRL)
                     && reg_wdata[bsc_pkg::CTRL_SOFT_RESET_BIT];
    assign capturing = (capture_cnt != 2'h0);

    // capture window after hard reset release or soft reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            capture_cnt <= bsc_pkg::CAPTURE_CYC;
        else if (clk_en)
        begin
            if (soft_go)
                capture_cnt <= bsc_pkg::CAPTURE_CYC; // R1
            else if (capturing)
                capture_cnt <= capture_cnt - 2'h1;
        end
    end

    // strap latch, frozen outside the capture window
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap     <= bsc_pkg::STRAP_RESET;
            phe_strap <= 1'b0;
        end
        else if (clk_en && capturing)
        begin
            strap     <= md_sync;  // R1 R12
            phe_strap <= phe_sync;
        end
    end

    // effective i/o decode of the function configuration registers
    always_comb
    begin
        if (strap.isa_mode)
            io_en = 1'b1;                      // R7
        else if (!phe_strap)
            io_en = 1'b0;                      // R6
        else
            io_en = strap.function_regs_in_io; // R3
    end

    // host i/o selects; attribute space decode lives elsewhere
    assign config_option_io_sel   = host_io_req && io_en
                        && (host_io_off == bsc_pkg::IO_OFF_CONFIG_OPTION);   // R4 R5
    assign card_status_io_sel     = host_io_req && io_en
                        && (host_io_off == bsc_pkg::IO_OFF_CARD_STATUS);     // R4 R5
    assign pin_replacement_io_sel = host_io_req && io_en
                        && (host_io_off == bsc_pkg::IO_OFF_PIN_REPLACEMENT); // R4 R5

    // registered copy of the decode enable for the host side
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            function_regs_in_io <= 1'b0;
        else if (clk_en)
            function_regs_in_io <= io_en;
    end

    // serial boot clock
    assign xfer    = (state == bsc_pkg::BS_CMD) || (state == bsc_pkg::BS_DATA);
    assign nv_cs_n = ~xfer;
    assign nv_sdo  = shift_out[31];
    assign to_sram = ~strap.boot_type_strap_lo;
    assign load_len = to_sram ? 16'(FW_LEN) : 16'(CIS_LEN);

    bsc_sck_gen #(
        .HIGH_CYC (bsc_pkg::NV_SCK_HIGH_CYC),
        .LOW_CYC  (bsc_pkg::NV_SCK_LOW_CYC)
    ) u_sck (
        .clk       (clk),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .run       (xfer),
        .sck       (nv_sck),      // R11
        .rise_tick (rise_tick),
        .fall_tick (fall_tick)
    );

    // boot load sequencer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state     <= bsc_pkg::BS_RESET;
            shift_out <= 32'h0000_0000;
            shift_in  <= 8'h00;
            bit_cnt   <= 5'h00;
            byte_cnt  <= 16'h0000;
            load_wr   <= '0;
        end
        else if (clk_en)
        begin
            load_wr.valid <= 1'b0;
            if (soft_go || capturing)
            begin
                state     <= bsc_pkg::BS_RESET;
                shift_out <= 32'h0000_0000;
            end
            else
            begin
                case (state)
                    bsc_pkg::BS_RESET:
                    begin
                        byte_cnt <= 16'h0000;
                        if (strap.boot_type_strap_hi)
                            state <= bsc_pkg::BS_UNSUPPORTED; // R10
                        else
                        begin
                            state     <= bsc_pkg::BS_CMD;
                            shift_out <= {bsc_pkg::NV_READ_CMD, bsc_pkg::NV_START_ADDR};
                            bit_cnt   <= bsc_pkg::NV_HDR_BITS;
                        end
                    end
                    bsc_pkg::BS_CMD:
                    begin
                        if (fall_tick)
                        begin
                            shift_out <= {shift_out[30:0], 1'b0};
                            if (bit_cnt == 5'h00)
                            begin
                                state   <= bsc_pkg::BS_DATA;
                                bit_cnt <= {2'b00, bsc_pkg::NV_BYTE_BITS};
                            end
                            else
                                bit_cnt <= bit_cnt - 5'h01;
                        end
                    end
                    bsc_pkg::BS_DATA:
                    begin
                        if (rise_tick)
                        begin
                            shift_in <= {shift_in[6:0], sdi_sync};
                            if (bit_cnt == 5'h00)
                            begin
                                load_wr.valid   <= 1'b1;
                                load_wr.to_sram <= to_sram;       // R8 R9
                                load_wr.addr    <= byte_cnt;
                                load_wr.data    <= {shift_in[6:0], sdi_sync};
                                byte_cnt        <= byte_cnt + 16'h0001;
                                bit_cnt         <= {2'b00, bsc_pkg::NV_BYTE_BITS};
                                if (byte_cnt == load_len - 16'h0001)
                                    state <= to_sram ? bsc_pkg::BS_RUN
                                                     : bsc_pkg::BS_WAIT_HOST; // R8 R9
                            end
                            else
                                bit_cnt <= bit_cnt - 5'h01;
                        end
                    end
                    default:
                        state <= state;
                endcase
            end
        end
    end

    assign wait_host = (state == bsc_pkg::BS_WAIT_HOST); // R9

    // register read port, data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 32'h0000_0000;
        else if (clk_en)
        begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd && (reg_addr == bsc_pkg::REG_STRAP))
            begin
                reg_rdata[15:0]                     <= strap;
                reg_rdata[bsc_pkg::STRAP_PHE_BIT]   <= phe_strap;
                reg_rdata[bsc_pkg::STRAP_IO_EN_BIT] <= io_en;
            end
            else if (reg_rd && (reg_addr == bsc_pkg::REG_STATUS))
            begin
                reg_rdata[bsc_pkg::STATUS_STATE_LSB +: 3] <= 3'(state);
                reg_rdata[bsc_pkg::STATUS_UNSUP_BIT]     <= (state == bsc_pkg::BS_UNSUPPORTED);
                reg_rdata[bsc_pkg::STATUS_WAIT_BIT]      <= wait_host;
                reg_rdata[bsc_pkg::STATUS_COUNT_LSB +: 16] <= byte_cnt;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [7:0] sck_hi_cnt;

    // counts enabled cycles of the sck high phase
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sck_hi_cnt <= 8'h00;
        else if (clk_en)
            sck_hi_cnt <= nv_sck ? sck_hi_cnt + 8'h01 : 8'h00;
    end

    sequence s_soft_req;
        clk_en && soft_go;
    endsequence

    sequence s_load_done;
        clk_en && rise_tick && (state == bsc_pkg::BS_DATA) && (bit_cnt == 5'h00)
        && (byte_cnt == load_len - 16'h0001) && !capturing && !soft_go;
    endsequence

    AST_CAPTURE_TRACK: assert property (clk_en && capturing |=> strap == $past(md_sync)) // R1
        else $error("strap not sampled during capture");
    AST_STRAP_HOLD: assert property (!capturing && !soft_go |=> $stable(strap)) // R12
        else $error("strap changed outside reset");
    AST_SOFT_RECAPTURE: assert property (s_soft_req |=> capturing ##1 capturing) // R1
        else $error("soft reset did not reopen capture");
    AST_ISA_FORCE: assert property (strap.isa_mode |-> io_en) // R7
        else $error("isa mode did not force io decode");
    AST_PHE_IGNORE: assert property (!strap.isa_mode && !phe_strap |-> !io_en) // R6
        else $error("io decode strap honoured without parallel host");
    AST_IO_DECODE: assert property (host_io_req && io_en // R4
        && host_io_off == bsc_pkg::IO_OFF_CARD_STATUS
        |-> card_status_io_sel && !config_option_io_sel)
        else $error("card status register not decoded at i/o offset");
    AST_ATTR_ONLY: assert property (!io_en // R5
        |-> !(config_option_io_sel || card_status_io_sel || pin_replacement_io_sel))
        else $error("function register decoded in i/o space");
    AST_SCK_HIGH: assert property ($fell(nv_sck) && xfer // R11
        |-> $past(sck_hi_cnt) == 8'(bsc_pkg::NV_SCK_HIGH_CYC - 1))
        else $error("sck high phase length wrong");
    AST_UNSUP_QUIET: assert property (state == bsc_pkg::BS_UNSUPPORTED // R10
        |-> nv_cs_n && !load_wr.valid)
        else $error("unsupported boot type accessed device");
    AST_LOAD_END: assert property (s_load_done |=> load_wr.valid // R8 R9
        && (state == (to_sram ? bsc_pkg::BS_RUN : bsc_pkg::BS_WAIT_HOST)))
        else $error("load did not end in the right state");

endmodule : bsc_top

//--- bsc_pkg.sv
// Purpose: shared constants and types for the boot strap configuration block
// Assumes: 10 MHz core clock, 16 data pins carry the strap word at reset
// Notes:   register offsets and field positions live here only
package bsc_pkg;

    // core clock and serial boot clock
    localparam int CLK_FREQ_HZ       = 10_000_000;
    localparam int NV_SCK_FREQ_HZ    = 400_000;
    localparam int NV_SCK_PERIOD_CYC = CLK_FREQ_HZ / NV_SCK_FREQ_HZ;
    localparam int NV_SCK_HIGH_CYC   = NV_SCK_PERIOD_CYC / 2;
    localparam int NV_SCK_LOW_CYC    = NV_SCK_PERIOD_CYC - NV_SCK_HIGH_CYC;

    // strap capture window: two synchroniser stages plus one sample
    localparam logic [1:0] CAPTURE_CYC = 2'h3;

    // register map
    localparam logic [7:0] REG_STRAP  = 8'h00;
    localparam logic [7:0] REG_CTRL   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // register fields
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int STRAP_PHE_BIT       = 16;
    localparam int STRAP_IO_EN_BIT     = 17;
    localparam int STATUS_STATE_LSB    = 0;
    localparam int STATUS_UNSUP_BIT    = 4;
    localparam int STATUS_WAIT_BIT     = 5;
    localparam int STATUS_COUNT_LSB    = 16;

    // host i/o offsets of the function configuration registers
    localparam logic [7:0] IO_OFF_CONFIG_OPTION  = 8'h40;
    localparam logic [7:0] IO_OFF_CARD_STATUS    = 8'h42;
    localparam logic [7:0] IO_OFF_PIN_REPLACEMENT = 8'h44;

    // reset values
    localparam logic [15:0] STRAP_RESET = 16'h0000;

    // serial boot device access
    localparam logic [7:0]  NV_READ_CMD   = 8'h03;
    localparam logic [23:0] NV_START_ADDR = 24'h00_0000;
    localparam logic [4:0]  NV_HDR_BITS   = 5'h1f;
    localparam logic [2:0]  NV_BYTE_BITS  = 3'h7;

    // strap word as sampled from the memory data pins
    typedef struct packed {
        logic       boot_type_strap_hi;
        logic       boot_type_strap_lo;
        logic       reserved13;
        logic       four_wire;
        logic       start_idle;
        logic       mem16;
        logic       nv_disable;
        logic       rom_disable;
        logic       isa_mode;
        logic       function_regs_in_io;
        logic [5:0] spare;
    } bsc_strap_type;

    // one loaded byte headed for sram or the card information area
    typedef struct packed {
        logic        valid;
        logic        to_sram;
        logic [15:0] addr;
        logic [7:0]  data;
    } bsc_load_wr_type;

    typedef enum {
        BS_RESET,
        BS_CMD,
        BS_DATA,
        BS_RUN,
        BS_WAIT_HOST,
        BS_UNSUPPORTED
    } bsc_state_type;

endpackage : bsc_pkg

//--- bsc_sync2.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static or slow against clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module bsc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta;

    // two stage capture
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            dout <= '0;
        end
        else if (clk_en)
        begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : bsc_sync2

//--- bsc_sck_gen.sv
// Purpose: serial boot clock generator with edge ticks
// Assumes: run held high for the whole transfer
// Notes:   clock idles low; low phase comes first
`timescale 1ns/1ps
module bsc_sck_gen #(
    parameter int HIGH_CYC = bsc_pkg::NV_SCK_HIGH_CYC,
    parameter int LOW_CYC  = bsc_pkg::NV_SCK_LOW_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic clk_en,
    input  wire logic run,
    output logic      sck,
    output logic      rise_tick,
    output logic      fall_tick
);

    logic [7:0] cnt;

    // ticks mark the edge where sck changes
    assign rise_tick = run && clk_en && !sck && (cnt == 8'(LOW_CYC - 1));
    assign fall_tick = run && clk_en && sck && (cnt == 8'(HIGH_CYC - 1));

    // phase counter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= 8'h00;
            sck <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!run)
            begin
                cnt <= 8'h00;
                sck <= 1'b0;
            end
            else if (rise_tick || fall_tick)
            begin
                cnt <= 8'h00;
                sck <= ~sck;
            end
            else
            begin
                cnt <= cnt + 8'h01;
            end
        end
    end

endmodule : bsc_sck_gen

//--- bsc_nv_model.sv
// Purpose: board model with strap resistors and a serial boot memory
// Assumes: read command plus 24-bit address, then data out msb first
// Notes:   byte n reads as 8'ha5 ^ n; data changes on the falling clock
`timescale 1ns/1ps
module bsc_nv_model (
    input  wire logic [15:0] pull_up,
    input  wire logic        md_busy,
    output logic      [15:0] md_pin,
    input  wire logic        nv_sck,
    input  wire logic        nv_cs_n,
    input  wire logic        nv_sdo,
    output logic             nv_sdi,
    output logic      [31:0] hdr
);
    int         bit_cnt = 0;
    int         idx;
    logic [7:0] cur;
    logic       sdo_r = 1'b0;

    // unpulled pins read low; busy pins carry other traffic
    assign md_pin = md_busy ? ~pull_up : pull_up;
    // deselected line shows the inverse of its last level
    assign nv_sdi = nv_cs_n ? ~sdo_r : sdo_r;

    // header bits taken on the rising clock; deselect restarts the count
    always @(posedge nv_sck or posedge nv_cs_n)
    begin
        if (nv_cs_n)
            bit_cnt = 0;
        else
        begin
            if (bit_cnt < 32)
                hdr = {hdr[30:0], nv_sdo};
            bit_cnt++;
        end
    end

    // data bits launched on the falling clock
    always @(negedge nv_sck)
    begin
        if (!nv_cs_n && bit_cnt >= 32)
        begin
            idx = bit_cnt - 32;
            cur = 8'ha5 ^ 8'(idx / 8);
            sdo_r = cur[7 - idx % 8];
        end
    end
endmodule : bsc_nv_model

//--- tb_bsc_top.sv
// Purpose: self-checking bench for the boot strap configuration block
// Assumes: short load lengths; straps set through the board model
// Notes:   one task per scenario, soft reset re-samples straps
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_bsc_top;
    localparam int FW  = 4;
    localparam int CIS = 2;
    logic                     clk       = 1'b0;
    logic                     rstn      = 1'b0;
    logic [15:0]              pull      = 16'h0000;
    logic                     busy      = 1'b0;
    logic                     phe       = 1'b0;
    logic [7:0]               reg_addr  = 8'h00;
    logic [31:0]              reg_wdata = 32'h0000_0000;
    logic                     reg_wr    = 1'b0;
    logic                     reg_rd    = 1'b0;
    logic                     io_req    = 1'b0;
    logic [7:0]               io_off    = 8'h00;
    logic [31:0]              reg_rdata;
    logic                     opt_sel;
    logic                     stat_sel;
    logic                     pin_sel;
    logic                     fio;
    logic                     sck;
    logic                     cs_n;
    logic                     sdo;
    logic                     sdi;
    logic                     wait_host;
    logic [15:0]              md;
    logic [31:0]              hdr;
    bsc_pkg::bsc_load_wr_type load_wr;
    int                       n_errors    = 0;
    int                       checks_done = 0;

    // 10 MHz core clock
    always #50 clk = ~clk;

    bsc_top #(.FW_LEN(FW), .CIS_LEN(CIS)) i_bsc_top (
        .clk(clk), .rstn(rstn), .clk_en(1'b1), .md_pin(md),
        .parallel_host_enable(phe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .host_io_req(io_req), .host_io_off(io_off), .config_option_io_sel(opt_sel),
        .card_status_io_sel(stat_sel), .pin_replacement_io_sel(pin_sel),
        .function_regs_in_io(fio),
        .nv_sck(sck), .nv_cs_n(cs_n), .nv_sdo(sdo), .nv_sdi(sdi),
        .load_wr(load_wr), .wait_host(wait_host)
    );

    bsc_nv_model i_bsc_nv_model (
        .pull_up(pull), .md_busy(busy), .md_pin(md), .nv_sck(sck),
        .nv_cs_n(cs_n), .nv_sdo(sdo), .nv_sdi(sdi), .hdr(hdr)
    );

    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk);
    endtask : reg_read

    // new board straps, then soft reset to sample them
    task automatic strap(input logic [15:0] s, input logic p);
        pull <= s;
        phe <= p;
        cyc(3);
        reg_write(bsc_pkg::REG_CTRL, 32'h0000_0001);
        cyc(5);
    endtask : strap

    task automatic io_probe(input logic e);
        logic [7:0] o;
        for (int k = 0; k < 4; k++)
        begin
            o = 8'h40 + 8'(2 * k);
            io_off <= o;
            io_req <= 1'b1;
            #1;
            `CHK("opt_sel", e & (o == 8'h40), opt_sel)
            `CHK("stat_sel", e & (o == 8'h42), stat_sel)
            `CHK("pin_sel", e & (o == 8'h44), pin_sel)
            @(posedge clk);
        end
        io_req <= 1'b0;
    endtask : io_probe

    // every phe, isa and io-decode strap combination
    task automatic t_decode;
        logic [2:0]  c;
        logic        e;
        logic [31:0] d;
        reg_read(bsc_pkg::REG_STRAP, d);
        `CHK("strap_default", 32'h0000_0000, d)
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            e = c[1] | (c[2] & c[0]);
            strap({8'h80, c[1], c[0], 6'h00}, c[2]);
            `CHK("io_decode", e, fio)
            reg_read(bsc_pkg::REG_STRAP, d);
            `CHK("strap_word", {14'h0000, e, c[2], 8'h80, c[1], c[0], 6'h00}, d)
            io_probe(e);
        end
        $display("test decode done");
    endtask : t_decode

    // pins move after capture; latched value must not
    task automatic t_hold;
        logic [31:0] d;
        strap(16'h8040, 1'b1);
        busy <= 1'b1;
        cyc(6);
        reg_read(bsc_pkg::REG_STRAP, d);
        `CHK("strap_hold", 16'h8040, d[15:0])
        `CHK("io_hold", 1'b1, fio)
        reg_read(bsc_pkg::REG_CTRL, d);
        `CHK("ctrl_read", 32'h0000_0000, d)
        reg_read(8'hfc, d);
        `CHK("unmapped_read", 32'h0000_0000, d)
        busy <= 1'b0;
        $display("test hold done");
    endtask : t_hold

    // boot types 10 and 11 start no serial access
    task automatic t_unsup;
        logic [31:0] d;
        int          act;
        for (int i = 0; i < 2; i++)
        begin
            act = 0;
            strap(i == 0 ? 16'h8000 : 16'hc000, 1'b1);
            repeat (200)
            begin
                @(posedge clk);
                if (cs_n !== 1'b1)
                    act++;
            end
            `CHK("unsup_cs", 0, act)
            reg_read(bsc_pkg::REG_STATUS, d);
            `CHK("unsup_flag", 6'h15, d[5:0])
        end
        $display("test unsupported done");
    endtask : t_unsup

    // serial clock high and low phase lengths
    task automatic sck_period;
        int h;
        int l;
        h = 0;
        l = 0;
        while (sck !== 1'b1 && l < 100)
        begin
            @(posedge clk);
            #1;
            l++;
        end
        l = 0;
        while (sck === 1'b1 && h < 100)
        begin
            @(posedge clk);
            #1;
            h++;
        end
        while (sck !== 1'b1 && l < 100)
        begin
            @(posedge clk);
            #1;
            l++;
        end
        if (h >= 100 || l >= 100)
        begin
            $display("MISMATCH sck_toggle exp toggling got stuck");
            n_errors++;
            test_done();
        end
        `CHK("sck_high", bsc_pkg::NV_SCK_HIGH_CYC, h)
        `CHK("sck_period", 25, h + l)
        @(posedge clk);
    endtask : sck_period

    // full boot load of n bytes for one device type
    task automatic t_load(input logic [15:0] s, input int n, input logic ram);
        logic [31:0] d;
        int          got;
        got = 0;
        strap(s, 1'b1);
        sck_period();
        for (int t = 0; t < 3000 && got < n; t++)
        begin
            @(posedge clk);
            #1;
            if (load_wr.valid === 1'b1)
            begin
                `CHK("load_dst", ram, load_wr.to_sram)
                `CHK("load_addr", 16'(got), load_wr.addr)
                `CHK("load_data", 8'ha5 ^ 8'(got), load_wr.data)
                got++;
            end
        end
        if (got < n)
        begin
            $display("MISMATCH load_count exp %0d got %0d", n, got);
            n_errors++;
            test_done();
        end
        cyc(40);
        `CHK("read_header", {bsc_pkg::NV_READ_CMD, bsc_pkg::NV_START_ADDR}, hdr)
        `CHK("cs_released", 1'b1, cs_n)
        `CHK("wait_host", ~ram, wait_host)
        reg_read(bsc_pkg::REG_STATUS, d);
        `CHK("load_state", ram ? 3'h3 : 3'h4, d[2:0])
        `CHK("load_total", 16'(n), d[31:16])
        $display("test load done");
    endtask : t_load

    initial
    begin
        cyc(8);
        rstn <= 1'b1;
        cyc(6);
        t_decode();
        t_hold();
        t_unsup();
        t_load(16'h0000, FW, 1'b1);
        t_load(16'h4000, CIS, 1'b0);
        test_done();
    end
endmodule : tb_bsc_top
